// *** fpa_div.sv ***
`timescale 1ns/1ns
// Restoring mantissa divider, two quotient bits per clock
module fpa_div (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Divider link
	fpa_div_if.div dv
);
	localparam int MW = fpa_pkg::FPA_MANT_W;
	localparam int QW = fpa_pkg::FPA_QUOT_W;
	localparam int CW = fpa_pkg::FPA_CNT_W;
	localparam logic [CW-1:0] STEPS =
		CW'(fpa_pkg::FPA_QUOT_W / fpa_pkg::FPA_DIV_PER_CYC);

	logic [MW+1:0] rem_q;
	logic [MW+1:0] rem_d;
	logic [MW-1:0] dsr_q;
	logic [QW-1:0] quot_q;
	logic [QW-1:0] quot_d;
	logic [CW-1:0] cnt_q;

	always_comb begin
		rem_d = rem_q;
		quot_d = quot_q;
		for (int i = 0; i < fpa_pkg::FPA_DIV_PER_CYC; i++) begin
			if (rem_d >= {2'h0, dsr_q}) begin
				rem_d = rem_d - {2'h0, dsr_q};
				quot_d = {quot_d[QW-2:0], 1'h1};
			end else begin
				quot_d = {quot_d[QW-2:0], 1'h0};
			end
			rem_d = {rem_d[MW:0], 1'h0};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rem_q <= '0;
			dsr_q <= '0;
			quot_q <= '0;
			cnt_q <= '0;
		end else if (dv.start) begin
			rem_q <= {2'h0, dv.dividend};
			dsr_q <= dv.divisor;
			quot_q <= '0;
			cnt_q <= STEPS;
		end else if (cnt_q != '0) begin
			rem_q <= rem_d;
			quot_q <= quot_d;
			cnt_q <= cnt_q - CW'(1);
		end
	end

	// Quotient holds after the last step until the next start
	assign dv.quot = quot_q;
	assign dv.sticky = (rem_q != '0);
endmodule : fpa_div

// *** fpa_div_if.sv ***
`timescale 1ns/1ns
// Link between the unit and its mantissa divider
interface fpa_div_if;
	logic start;
	logic [fpa_pkg::FPA_MANT_W-1:0] dividend;
	logic [fpa_pkg::FPA_MANT_W-1:0] divisor;
	logic [fpa_pkg::FPA_QUOT_W-1:0] quot;
	logic sticky;

	modport ctrl (
		output start,
		output dividend,
		output divisor,
		input quot,
		input sticky
	);
	modport div (
		input start,
		input dividend,
		input divisor,
		output quot,
		output sticky
	);
endinterface : fpa_div_if

// *** fpa_pipe_model.sv ***
`timescale 1ns/1ns
// Pipeline side model that issues operations and times their completion
module fpa_pipe_model (
	// Clock
	input wire logic i_clk,
	// Unit status
	input wire logic i_busy,
	input wire logic i_done,
	// Issue
	output logic o_valid,
	output logic [1:0] o_code,
	output logic [31:0] o_src_a,
	output logic [31:0] o_src_b
);
	int lat;
	initial begin
		o_valid = 1'h0;
		o_code = 2'h0;
		o_src_a = 32'h0;
		o_src_b = 32'h0;
	end
	// A stray request during busy checks that the unit refuses it
	task automatic issue(input logic [1:0] op, input logic [31:0] a, b,
		input logic extra);
		@(posedge i_clk);
		// The pipeline holds a new operation back while the unit is busy
		while (i_busy === 1'h1)
			@(posedge i_clk);
		o_valid <= 1'h1;
		o_code <= op;
		o_src_a <= a;
		o_src_b <= b;
		@(posedge i_clk);
		o_valid <= 1'h0;
		lat = 0;
		do begin
			@(posedge i_clk);
			lat++;
			o_valid <= extra && lat == 1;
		end while (i_done !== 1'h1 && lat < 64);
	endtask : issue
endmodule : fpa_pipe_model

// *** fpa_pkg.sv ***
// Shared constants and types for the floating-point arithmetic unit
package fpa_pkg;
	typedef enum logic [1:0] {
		FPA_OP_ADD = 2'h0,
		FPA_OP_RSUB = 2'h1,
		FPA_OP_MUL = 2'h2,
		FPA_OP_DIV = 2'h3
	} fpa_op_t;

	// Operand layout
	localparam int FPA_W = 32;
	localparam int FPA_SIGN_BIT = 31;
	localparam int FPA_FRAC_W = 23;
	localparam int FPA_QUIET_BIT = 22;
	localparam int FPA_MANT_W = 24;
	localparam logic [7:0] FPA_EXP_MAX = 8'hff;
	localparam logic signed [10:0] FPA_BIAS = 11'sh07f;
	localparam logic [31:0] FPA_QNAN = 32'hffc00000;

	// Internal widths
	localparam int FPA_NORM_W = 52;
	localparam int FPA_GUARD = 27;
	localparam int FPA_QUOT_W = 28;
	localparam int FPA_DIV_PER_CYC = 2;
	localparam int FPA_CNT_W = 5;

	// Exception cause and status flag positions
	localparam int FPA_CAUSE_W = 5;
	localparam logic [4:0] FPA_CAUSE_FP = 5'h06;
	localparam int FPA_FLAGS_W = 5;
	localparam int FPA_FLAG_DZ = 0;
	localparam int FPA_FLAG_OF = 1;
	localparam int FPA_FLAG_UF = 2;
	localparam int FPA_FLAG_IO = 3;
	localparam int FPA_FLAG_DO = 4;

	// Register port
	localparam int FPA_ADDR_W = 4;
	localparam logic [3:0] FPA_REG_STATUS = 4'h0;
	localparam logic [3:0] FPA_REG_CAUSE = 4'h4;
	localparam logic [3:0] FPA_REG_RESULT = 4'h8;

	// Latencies in cycles per area setting
	localparam int FPA_LAT_AR_0 = 4;
	localparam int FPA_LAT_AR_1 = 6;
	localparam int FPA_LAT_AR_2 = 1;
	localparam int FPA_LAT_DIV_0 = 28;
	localparam int FPA_LAT_DIV_1 = 30;
	localparam int FPA_LAT_DIV_2 = 24;
endpackage : fpa_pkg

// *** fpa_unit.sv ***
`timescale 1ns/1ns
// Floating-point add, reverse subtract, multiply and divide unit
// Contract
// (RQ1) Add writes sum of both sources
// (RQ2) Reverse subtract writes second minus first
// (RQ3) Multiply writes product of both sources
// (RQ4) Divide writes second divided by first
// (RQ5) Denormal operand wins: quiet NaN, flag, cause
// (RQ6) Add invalid: signaling NaN, opposite infinities
// (RQ7) Subtract invalid: signaling NaN, same-sign infinities
// (RQ8) Multiply invalid: signaling NaN, zero times infinity
// (RQ9) Divide invalid: signaling NaN, both zero, both infinite
// (RQ10) Quiet NaN gives NaN without flags
// (RQ11) Denormal result gives signed zero, underflow
// (RQ12) Too large result gives signed infinity, overflow
// (RQ13) Zero divisor gives infinity, divide-by-zero flag; the code gives infinity without the flag when the dividend is infinite
// (RQ14) Exception leaves destination unwritten, updates cause
// (RQ15) Arithmetic latency 4, 6 or 1
// (RQ16) Divide latency 28, 30 or 24
// (RQ17) Unit present only when enable parameter positive
// (RQ18) Operands are 32-bit single-precision values
// (RQ19) Round to nearest even; flags stay sticky
module fpa_unit #(
	parameter int AREA_OPT_LEVEL = 0,
	parameter int FPU_ENABLE_PARAM = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Operation issue
	input wire logic i_op_valid,
	input wire logic [1:0] i_op_code,
	input wire logic [fpa_pkg::FPA_W-1:0] i_src_a,
	input wire logic [fpa_pkg::FPA_W-1:0] i_src_b,
	output logic o_busy,
	// Completion
	output logic o_done,
	output logic o_rd_wr,
	output logic [fpa_pkg::FPA_W-1:0] o_result,
	output logic o_exception,
	output logic [fpa_pkg::FPA_CAUSE_W-1:0] o_cause,
	output logic [fpa_pkg::FPA_FLAGS_W-1:0] o_flags,
	// Register port
	input wire logic [fpa_pkg::FPA_ADDR_W-1:0] i_reg_addr,
	input wire logic [fpa_pkg::FPA_W-1:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [fpa_pkg::FPA_W-1:0] o_reg_rdata
);
	localparam int W = fpa_pkg::FPA_W;
	localparam int SB = fpa_pkg::FPA_SIGN_BIT;
	localparam int FW = fpa_pkg::FPA_FRAC_W;
	localparam int MW = fpa_pkg::FPA_MANT_W;
	localparam int NW = fpa_pkg::FPA_NORM_W;
	localparam int G = fpa_pkg::FPA_GUARD;
	localparam int CW = fpa_pkg::FPA_CNT_W;
	localparam int NF = fpa_pkg::FPA_FLAGS_W;
	localparam logic [7:0] EMAX = fpa_pkg::FPA_EXP_MAX;
	localparam logic [CW-1:0] LAT_ARITH = CW'((AREA_OPT_LEVEL == 2) ?
		fpa_pkg::FPA_LAT_AR_2 : (AREA_OPT_LEVEL == 1) ?
		fpa_pkg::FPA_LAT_AR_1 : fpa_pkg::FPA_LAT_AR_0);
	localparam logic [CW-1:0] LAT_DIV = CW'((AREA_OPT_LEVEL == 2) ?
		fpa_pkg::FPA_LAT_DIV_2 : (AREA_OPT_LEVEL == 1) ?
		fpa_pkg::FPA_LAT_DIV_1 : fpa_pkg::FPA_LAT_DIV_0);
	localparam logic UNIT_ON = (FPU_ENABLE_PARAM > 0);
	localparam logic [CW-1:0] ONE = CW'(1);

	function automatic logic f_zero(input logic [W-1:0] x);
		return x[SB-1:0] == '0;
	endfunction : f_zero

	function automatic logic f_den(input logic [W-1:0] x);
		return x[SB-1:FW] == 8'h00 && x[FW-1:0] != '0;
	endfunction : f_den

	function automatic logic f_inf(input logic [W-1:0] x);
		return x[SB-1:FW] == EMAX && x[FW-1:0] == '0;
	endfunction : f_inf

	function automatic logic f_nan(input logic [W-1:0] x);
		return x[SB-1:FW] == EMAX && x[FW-1:0] != '0;
	endfunction : f_nan

	function automatic logic f_snan(input logic [W-1:0] x);
		return f_nan(x) && !x[fpa_pkg::FPA_QUIET_BIT];
	endfunction : f_snan

	function automatic logic f_qnan(input logic [W-1:0] x);
		return f_nan(x) && x[fpa_pkg::FPA_QUIET_BIT];
	endfunction : f_qnan

	// Mantissa with the hidden bit, zero for a zero operand
	function automatic logic [MW-1:0] f_mant(input logic [W-1:0] x);
		return {x[SB-1:FW] != 8'h00, x[FW-1:0]};
	endfunction : f_mant

	function automatic logic signed [10:0] f_exp(input logic [W-1:0] x);
		return $signed({3'h0, x[SB-1:FW]});
	endfunction : f_exp

	// Normalise, round to nearest even and range check; the value is
	// m / 2^(NW-1) * 2^(e - bias). Returns {underflow, overflow, result}.
	function automatic logic [W+1:0] f_round(input logic s,
		input logic signed [10:0] e, input logic [NW-1:0] m);
		logic [NW-1:0] n;
		logic signed [10:0] ex;
		logic [FW:0] r;
		logic up;
		n = m;
		ex = e;
		r = '0;
		up = 1'h0;
		if (m == '0)
			return {2'h0, s, 31'h0};
		for (int i = 0; i < NW; i++) begin
			if (!n[NW-1]) begin
				n = {n[NW-2:0], 1'h0};
				ex = ex - 11'sh001;
			end
		end
		up = n[G] && (n[G-1:0] != '0 || n[G+1]); // RQ19
		r = {1'h0, n[NW-2:G+1]} + (FW+1)'(up);
		if (r[FW])
			ex = ex + 11'sh001;
		if (ex <= 11'sh000)
			return {2'h2, s, 31'h0}; // RQ11
		if (ex >= $signed({3'h0, EMAX}))
			return {2'h1, s, EMAX, 23'h0}; // RQ12
		return {2'h0, s, ex[7:0], r[FW-1:0]};
	endfunction : f_round

	fpa_div_if dv ();

	fpa_div u_div (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.dv(dv)
	);

	fpa_pkg::fpa_op_t op_q;
	fpa_pkg::fpa_op_t op_s;
	logic busy_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] lat_s;
	logic [W-1:0] a_q;
	logic [W-1:0] b_q;
	logic [W-1:0] a_s;
	logic [W-1:0] b_s;
	logic accept;
	logic fin;
	logic done_q;
	logic wr_q;
	logic exc_q;
	logic [W-1:0] result_q;
	logic [fpa_pkg::FPA_CAUSE_W-1:0] cause_q;
	logic [NF-1:0] flags_q;
	logic [NF-1:0] flag_clr;
	logic [W-1:0] rdata_q;

	// Operands come from the inputs on the issue cycle, else the latches
	assign op_s = busy_q ? op_q : fpa_pkg::fpa_op_t'(i_op_code);
	assign a_s = busy_q ? a_q : i_src_a;
	assign b_s = busy_q ? b_q : i_src_b;
	assign lat_s = (op_s == fpa_pkg::FPA_OP_DIV) ? LAT_DIV : LAT_ARITH;
	// Issue is refused while busy, and always when the unit is absent
	assign accept = i_op_valid && !busy_q && UNIT_ON; // RQ17
	assign fin = (accept && lat_s == ONE) || (busy_q && cnt_q == ONE);

	// Divider starts on issue; first operand is the divisor
	assign dv.start = accept && op_s == fpa_pkg::FPA_OP_DIV; // RQ4
	assign dv.dividend = f_mant(i_src_b);
	assign dv.divisor = f_mant(i_src_a);

	// Add path: b plus a, with a negated for reverse subtract
	logic [W-1:0] add_v;
	logic [W-1:0] add_big;
	logic [W-1:0] add_sml;
	logic add_sub;
	logic [7:0] add_sh;
	logic [NW-1:0] add_x;
	logic [NW-1:0] add_y;
	logic [NW-1:0] add_ys;
	logic [NW-1:0] add_sum;
	logic [W+1:0] add_r;

	assign add_v = {a_s[SB] ^ (op_s == fpa_pkg::FPA_OP_RSUB),
		a_s[SB-1:0]}; // RQ2
	assign add_big = (b_s[SB-1:0] >= add_v[SB-1:0]) ? b_s : add_v;
	assign add_sml = (b_s[SB-1:0] >= add_v[SB-1:0]) ? add_v : b_s;
	assign add_sub = add_big[SB] ^ add_sml[SB];
	assign add_sh = add_big[SB-1:FW] - add_sml[SB-1:FW];
	assign add_x = {1'h0, f_mant(add_big), 27'h0};
	assign add_y = {1'h0, f_mant(add_sml), 27'h0};
	// Bits shifted out fold into a sticky bit so rounding stays exact
	assign add_ys = (add_sh >= 8'(NW)) ? {51'h0, add_y != '0} :
		((add_y >> add_sh) |
		{51'h0, (add_y & ((52'h1 << add_sh) - 52'h1)) != '0});
	assign add_sum = add_sub ? add_x - add_ys : add_x + add_ys; // RQ1

	always_comb begin
		if (f_inf(add_big))
			add_r = {2'h0, add_big};
		else
			add_r = f_round((add_sum == '0 && add_sub) ? 1'h0 :
				add_big[SB], f_exp(add_big) + 11'sh001, add_sum); // RQ18
	end

	// Multiply path
	logic mul_s;
	logic [2*MW-1:0] mul_p;
	logic [W+1:0] mul_r;

	assign mul_s = a_s[SB] ^ b_s[SB];
	assign mul_p = f_mant(a_s) * f_mant(b_s);

	always_comb begin
		if (f_zero(a_s) || f_zero(b_s))
			mul_r = {2'h0, mul_s, 31'h0};
		else if (f_inf(a_s) || f_inf(b_s))
			mul_r = {2'h0, mul_s, EMAX, 23'h0};
		else
			mul_r = f_round(mul_s, f_exp(a_s) + f_exp(b_s) -
				fpa_pkg::FPA_BIAS + 11'sh001, {mul_p, 4'h0}); // RQ3
	end

	// Divide path, quotient from the divider
	logic [W+1:0] div_r;

	always_comb begin
		if (f_inf(b_s))
			div_r = {2'h0, mul_s, EMAX, 23'h0};
		else if (f_inf(a_s) || f_zero(b_s))
			div_r = {2'h0, mul_s, 31'h0};
		else
			div_r = f_round(mul_s, f_exp(b_s) - f_exp(a_s) +
				fpa_pkg::FPA_BIAS, {dv.quot, 24'h0} |
				{51'h0, dv.sticky}); // RQ4
	end

	// Exception priority and final result
	logic op_inv;
	logic op_dz;
	logic exc_d;
	logic [NF-1:0] flag_d;
	logic [W-1:0] res_d;
	logic [W+1:0] path_r;

	always_comb begin
		case (op_s)
		fpa_pkg::FPA_OP_ADD:
			op_inv = f_inf(a_s) && f_inf(b_s) &&
				a_s[SB] != b_s[SB]; // RQ6
		fpa_pkg::FPA_OP_RSUB:
			op_inv = f_inf(a_s) && f_inf(b_s) &&
				a_s[SB] == b_s[SB]; // RQ7
		fpa_pkg::FPA_OP_MUL:
			op_inv = (f_zero(a_s) && f_inf(b_s)) ||
				(f_zero(b_s) && f_inf(a_s)); // RQ8
		fpa_pkg::FPA_OP_DIV:
			op_inv = (f_zero(a_s) && f_zero(b_s)) ||
				(f_inf(a_s) && f_inf(b_s)); // RQ9
		default:
			op_inv = 1'h0;
		endcase
		op_inv = op_inv || f_snan(a_s) || f_snan(b_s);
		op_dz = op_s == fpa_pkg::FPA_OP_DIV && f_zero(a_s) &&
			!f_inf(b_s);
		case (op_s)
		fpa_pkg::FPA_OP_MUL:
			path_r = mul_r;
		fpa_pkg::FPA_OP_DIV:
			path_r = div_r;
		default:
			path_r = add_r;
		endcase
		flag_d = '0;
		exc_d = 1'h0;
		res_d = fpa_pkg::FPA_QNAN;
		if (f_den(a_s) || f_den(b_s)) begin
			flag_d[fpa_pkg::FPA_FLAG_DO] = 1'h1; // RQ5
			exc_d = 1'h1;
		end else if (op_inv) begin
			flag_d[fpa_pkg::FPA_FLAG_IO] = 1'h1;
			exc_d = 1'h1;
		end else if (f_qnan(a_s) || f_qnan(b_s)) begin
			res_d = fpa_pkg::FPA_QNAN; // RQ10
		end else if (op_dz) begin
			res_d = {mul_s, EMAX, 23'h0}; // RQ13
			flag_d[fpa_pkg::FPA_FLAG_DZ] = 1'h1;
			exc_d = 1'h1;
		end else begin
			res_d = path_r[W-1:0];
			flag_d[fpa_pkg::FPA_FLAG_UF] = path_r[W+1]; // RQ11
			flag_d[fpa_pkg::FPA_FLAG_OF] = path_r[W]; // RQ12
			exc_d = path_r[W+1] || path_r[W];
		end
	end

	// Issue and latency count
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_q <= 1'h0;
			cnt_q <= '0;
			op_q <= fpa_pkg::FPA_OP_ADD;
			a_q <= '0;
			b_q <= '0;
		end else if (accept) begin
			busy_q <= lat_s != ONE;
			cnt_q <= lat_s - ONE; // RQ15 RQ16
			op_q <= op_s;
			a_q <= i_src_a;
			b_q <= i_src_b;
		end else if (busy_q) begin
			cnt_q <= cnt_q - ONE;
			if (cnt_q == ONE)
				busy_q <= 1'h0;
		end
	end

	// Completion; the destination write is withheld on an exception
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_q <= 1'h0;
			wr_q <= 1'h0;
			exc_q <= 1'h0;
			result_q <= '0;
		end else begin
			done_q <= fin;
			wr_q <= fin && !exc_d; // RQ14
			exc_q <= fin && exc_d;
			if (fin)
				result_q <= res_d;
		end
	end

	// Cause field and sticky flags; a new flag beats a same-cycle clear
	assign flag_clr = (i_reg_wr && i_reg_addr == fpa_pkg::FPA_REG_STATUS) ?
		i_reg_wdata[NF-1:0] : '0;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cause_q <= '0;
			flags_q <= '0;
		end else begin
			if (fin && exc_d)
				cause_q <= fpa_pkg::FPA_CAUSE_FP; // RQ14
			flags_q <= (flags_q & ~flag_clr) |
				(fin ? flag_d : '0); // RQ19
		end
	end

	// Register reads, data valid only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= '0;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
			fpa_pkg::FPA_REG_STATUS:
				rdata_q <= {27'h0, flags_q};
			fpa_pkg::FPA_REG_CAUSE:
				rdata_q <= {27'h0, cause_q};
			fpa_pkg::FPA_REG_RESULT:
				rdata_q <= result_q;
			default:
				rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign o_busy = busy_q;
	assign o_done = done_q;
	assign o_rd_wr = wr_q;
	assign o_result = result_q;
	assign o_exception = exc_q;
	assign o_cause = cause_q;
	assign o_flags = flags_q;
	assign o_reg_rdata = rdata_q;
endmodule : fpa_unit

// *** fpa_unit_properties.sv ***
`timescale 1ns/1ns
// Timing, pulse and flag assertions for the floating-point unit
module fpa_unit_properties #(
	parameter int AREA_OPT_LEVEL = 0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Operation port
	input wire logic i_op_valid,
	input wire logic [1:0] i_op_code,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_rd_wr,
	input wire logic o_exception,
	input wire logic [4:0] o_cause,
	input wire logic [4:0] o_flags,
	// Register port
	input wire logic [3:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] o_reg_rdata
);
	localparam int LAT = AREA_OPT_LEVEL == 1 ? 6 : AREA_OPT_LEVEL == 2 ? 1 : 4;
	localparam int LDIV = AREA_OPT_LEVEL == 1 ? 30 :
		AREA_OPT_LEVEL == 2 ? 24 : 28;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_take;
		i_op_valid && !o_busy;
	endsequence
	sequence s_arith_wait;
		o_busy [*3] ##1 (o_done && !o_busy);
	endsequence
	arith_lat_a: assert property (s_take ##0 i_op_code != 2'h3
		|-> ##LAT o_done) else $error("arithmetic done not at its latency");
	arith_busy_a: assert property (s_take ##0 i_op_code != 2'h3
		##0 LAT == 4 |=> s_arith_wait) else $error("busy window wrong");
	div_lat_a: assert property (s_take ##0 i_op_code == 2'h3
		|-> ##LDIV o_done) else $error("divide done not at its latency");
	div_quiet_a: assert property (s_take ##0 i_op_code == 2'h3
		|=> (o_busy && !o_done) [*8]) else $error("divide ended early");
	done_pulse_a: assert property (o_done && LAT > 1 |=> !o_done)
		else $error("done longer than one cycle");
	write_excl_a: assert property (o_done == (o_rd_wr || o_exception)
		&& !(o_rd_wr && o_exception)) else $error("write and exception clash");
	exc_cause_a: assert property (o_exception |-> o_cause == 5'h06)
		else $error("cause not set on exception");
	cause_hold_a: assert property (!o_exception |-> $stable(o_cause))
		else $error("cause changed without exception");
	flag_set_a: assert property ((o_flags & ~$past(o_flags)) != 5'h0
		|-> o_exception) else $error("flag set without exception");
	flag_sticky_a: assert property ((~o_flags & $past(o_flags)) != 5'h0
		|-> $past(i_reg_wr && i_reg_addr == 4'h0))
		else $error("flag dropped without clear");
	rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
		else $error("read data outside read cycle");
endmodule : fpa_unit_properties

bind fpa_unit fpa_unit_properties #(.AREA_OPT_LEVEL(AREA_OPT_LEVEL))
	fpa_unit_properties_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_op_valid(i_op_valid), .i_op_code(i_op_code), .o_busy(o_busy),
	.o_done(o_done), .o_rd_wr(o_rd_wr), .o_exception(o_exception),
	.o_cause(o_cause), .o_flags(o_flags), .i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

// *** testbench.sv ***
`timescale 1ns/1ns
// Self-checking bench for the floating-point arithmetic unit
module testbench;
	logic i_clk = 1'h0;
	logic i_rst_n = 1'h0;
	logic i_op_valid;
	logic [1:0] i_op_code;
	logic [31:0] i_src_a;
	logic [31:0] i_src_b;
	logic o_busy, o_done, o_rd_wr, o_exception;
	logic [31:0] o_result;
	logic [31:0] o_reg_rdata;
	logic [4:0] o_cause;
	logic [4:0] o_flags;
	logic [3:0] i_reg_addr = 4'h0;
	logic [31:0] i_reg_wdata = 32'h0;
	logic i_reg_wr = 1'h0;
	logic i_reg_rd = 1'h0;
	logic [31:0] rv;
	int errors = 0;
	int compares = 0;

	always #50 i_clk = ~i_clk;

	fpa_unit fpa_unit_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_src_a(i_src_a),
		.i_src_b(i_src_b), .o_busy(o_busy), .o_done(o_done),
		.o_rd_wr(o_rd_wr), .o_result(o_result), .o_exception(o_exception),
		.o_cause(o_cause), .o_flags(o_flags), .i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
		.o_reg_rdata(o_reg_rdata));
	fpa_pipe_model fpa_pipe_model_i (.i_clk(i_clk), .i_busy(o_busy),
		.i_done(o_done), .o_valid(i_op_valid), .o_code(i_op_code),
		.o_src_a(i_src_a), .o_src_b(i_src_b));

	task automatic check(input string what, input logic [31:0] exp, got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic conclude();
		$display("Comparisons %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'h1;
		@(posedge i_clk);
		i_reg_wr <= 1'h0;
	endtask : reg_wr

	// Read data are taken in the one cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_reg_addr <= a;
		i_reg_rd <= 1'h1;
		@(posedge i_clk);
		i_reg_rd <= 1'h0;
		@(posedge i_clk);
		d = o_reg_rdata;
	endtask : reg_rd

	// Flags are cleared first so each operation shows only its own
	task automatic run(input logic [1:0] op, input logic [31:0] a, b, res,
		input logic [4:0] fl);
		int lat_exp;
		lat_exp = fpa_pkg::FPA_LAT_AR_0;
		if (op == 2'h3)
			lat_exp = fpa_pkg::FPA_LAT_DIV_0;
		reg_wr(4'h0, 32'h1f);
		fpa_pipe_model_i.issue(op, a, b, 1'h0);
		check("result", res, o_result);
		check("write", {31'h0, fl == 5'h0}, {31'h0, o_rd_wr});
		check("exception", {31'h0, fl != 5'h0}, {31'h0, o_exception});
		check("flags", {27'h0, fl}, {27'h0, o_flags});
		if (fl != 5'h0)
			check("cause", 32'h6, {27'h0, o_cause});
		check("latency", lat_exp, 32'(fpa_pipe_model_i.lat));
	endtask : run

	task automatic t_arith();
		run(2'h0, 32'h3f800000, 32'h40000000, 32'h40400000, 5'h0);
		run(2'h1, 32'h3f800000, 32'h40400000, 32'h40000000, 5'h0);
		run(2'h2, 32'h40000000, 32'h40400000, 32'h40c00000, 5'h0);
		run(2'h3, 32'h40000000, 32'h40c00000, 32'h40400000, 5'h0);
		run(2'h0, 32'h3f800000, 32'h33800000, 32'h3f800000, 5'h0);
		run(2'h0, 32'h3f800001, 32'h33800000, 32'h3f800002, 5'h0);
	endtask : t_arith

	task automatic t_except();
		run(2'h0, 32'h00000001, 32'h7f800001, 32'hffc00000, 5'h10);
		run(2'h3, 32'h7fc00000, 32'h80000001, 32'hffc00000, 5'h10);
		run(2'h0, 32'h7f800000, 32'hff800000, 32'hffc00000, 5'h08);
		run(2'h0, 32'h3f800000, 32'h7f800001, 32'hffc00000, 5'h08);
		run(2'h1, 32'hff800000, 32'hff800000, 32'hffc00000, 5'h08);
		run(2'h2, 32'h00000000, 32'hff800000, 32'hffc00000, 5'h08);
		run(2'h2, 32'h7f800000, 32'h80000000, 32'hffc00000, 5'h08);
		run(2'h3, 32'h00000000, 32'h80000000, 32'hffc00000, 5'h08);
		run(2'h3, 32'h7f800000, 32'hff800000, 32'hffc00000, 5'h08);
		run(2'h2, 32'h7fc00000, 32'h3f800000, 32'hffc00000, 5'h00);
		run(2'h3, 32'h00000000, 32'h7fc00000, 32'hffc00000, 5'h00);
		run(2'h3, 32'h80000000, 32'h3f800000, 32'hff800000, 5'h01);
		run(2'h2, 32'h80800000, 32'h00800000, 32'h80000000, 5'h04);
		run(2'h3, 32'h7f000000, 32'h00800000, 32'h00000000, 5'h04);
		run(2'h2, 32'h7f000000, 32'h7f000000, 32'h7f800000, 5'h02);
		run(2'h1, 32'h7f7fffff, 32'hff7fffff, 32'hff800000, 5'h02);
	endtask : t_except

	task automatic t_regs();
		run(2'h0, 32'h3f800000, 32'h40000000, 32'h40400000, 5'h0);
		reg_rd(4'h8, rv);
		check("result reg", 32'h40400000, rv);
		run(2'h3, 32'h00000000, 32'h3f800000, 32'h7f800000, 5'h01);
		fpa_pipe_model_i.issue(2'h0, 32'h7f800000, 32'hff800000, 1'h0);
		check("sticky", 32'h09, {27'h0, o_flags});
		reg_rd(4'h0, rv);
		check("status reg", 32'h09, rv);
		reg_wr(4'h0, 32'h01);
		reg_rd(4'h0, rv);
		check("status clear", 32'h08, rv);
		reg_wr(4'h4, 32'h0);
		reg_rd(4'h4, rv);
		check("cause reg", 32'h06, rv);
		reg_rd(4'hc, rv);
		check("unmapped", 32'h0, rv);
	endtask : t_regs

	task automatic t_busy();
		int n;
		n = 0;
		fpa_pipe_model_i.issue(2'h0, 32'h3f800000, 32'h3f800000, 1'h1);
		check("busy result", 32'h40000000, o_result);
		check("busy latency", 32'h4, 32'(fpa_pipe_model_i.lat));
		repeat (8) begin
			@(posedge i_clk);
			if (o_done === 1'h1)
				n++;
		end
		check("refused op", 32'h0, 32'(n));
	endtask : t_busy

	initial begin
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'h1;
		@(posedge i_clk);
		t_arith();
		t_except();
		t_regs();
		t_busy();
		conclude();
	end

	// About 450 cycles are needed; 5000 cycles means a hang
	initial begin
		#(100 * 5000);
		errors++;
		conclude();
	end
endmodule : testbench
